/* File: hdl/stap_pkg.sv */
// shared constants and types of the scan test access port
// assumes a single core clock; the scan pins arrive asynchronous to it
package stap_pkg;

	// ****************************************
	// widths and fixed patterns
	// ****************************************
	localparam int STAP_IR_W = 8;
	localparam int STAP_DR_W = 8;
	localparam int STAP_SYNC_STAGES = 2;
	localparam logic [STAP_IR_W-1:0] STAP_IR_CAPTURE = 8'h81;
	localparam logic [STAP_IR_W-1:0] STAP_IR_BYPASS = 8'hFF;
	localparam logic [STAP_IR_W-1:0] STAP_IR_RESET = 8'hFF;
	localparam logic [STAP_DR_W-1:0] STAP_DR_RESET = 8'h00;
	localparam logic STAP_BYP_CAPTURE = 1'b0;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
		ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} stap_state_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} stap_pins_t;

	typedef struct packed {
		logic tdo;
		logic tdo_oe_n;
	} stap_tdo_t;

endpackage : stap_pkg

/* File: hdl/stap_sync.sv */
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is a slowly changing level relative to the core clock
`timescale 1ns/10ps
module stap_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// levels
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	import stap_pkg::*;

	logic [W-1:0] meta_q;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule : stap_sync

/* File: hdl/stap_buf.sv */
// two-entry buffer with registered output and a skid entry
// assumes producer and consumer sit on the core clock
`timescale 1ns/10ps
module stap_buf #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// fill side
	input wire logic i_in_valid,
	input wire logic [W-1:0] i_in_data,
	output logic o_in_ready,
	// drain side
	output logic o_out_valid,
	output logic [W-1:0] o_out_data,
	input wire logic i_out_ready
);
	import stap_pkg::*;

	logic skid_v_q;
	logic [W-1:0] skid_q;
	logic accept;
	logic drain;

	assign o_in_ready = !skid_v_q;
	assign accept = i_in_valid && !skid_v_q;
	assign drain = !o_out_valid || i_out_ready;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_out_valid <= 1'b0;
			o_out_data <= '0;
			skid_v_q <= 1'b0;
			skid_q <= '0;
		end else if (drain) begin
			if (skid_v_q) begin
				o_out_data <= skid_q;
				o_out_valid <= 1'b1;
				skid_v_q <= 1'b0;
			end else if (accept) begin
				o_out_data <= i_in_data;
				o_out_valid <= 1'b1;
			end else begin
				o_out_valid <= 1'b0;
			end
		end else if (accept) begin
			// head stalled: park the word in the second entry
			skid_q <= i_in_data;
			skid_v_q <= 1'b1;
		end
	end

endmodule : stap_buf

/* File: hdl/stap_top.sv */
// scan test access port: tap controller, instruction register, bypass and one data register
// assumes tck, tms, tdi and the sampled inputs are asynchronous and far slower than i_core_clk
`timescale 1ns/10ps
module stap_top (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// scan pins
	input wire stap_pkg::stap_pins_t i_pins,
	output logic o_tdo,
	output logic o_tdo_oe_n,
	// normal-function inputs sampled by the data register
	input wire logic [stap_pkg::STAP_DR_W-1:0] i_sys_in,
	// parallel output stage
	output logic [stap_pkg::STAP_DR_W-1:0] o_upd_data,
	output logic [stap_pkg::STAP_IR_W-1:0] o_ir,
	// updated words towards the user
	output logic o_word_valid,
	output logic [stap_pkg::STAP_DR_W-1:0] o_word_data,
	input wire logic i_word_ready
);
	import stap_pkg::*;

	// ****************************************
	// functions
	// ****************************************
	function automatic stap_state_t tap_next(input stap_state_t s, input logic tms);
		stap_state_t n;
		n = ST_TLR;
		case (s)
			ST_TLR: n = tms ? ST_TLR : ST_RTI;
			ST_RTI: n = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: n = tms ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: n = tms ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: n = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: n = tms ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: n = tms ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: n = tms ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: n = tms ? ST_SEL_DR : ST_RTI;
			default: n = ST_TLR;
		endcase
		return n;
	endfunction : tap_next

	function automatic logic is_bypass(input logic [STAP_IR_W-1:0] ir);
		return ir == STAP_IR_BYPASS;
	endfunction : is_bypass

	// ****************************************
	// pin synchronisation and tck edges
	// ****************************************
	logic [STAP_DR_W+2:0] sync_out;
	logic s_tck;
	logic s_tms;
	logic s_tdi;
	logic [STAP_DR_W-1:0] s_sys;
	logic tck_prev_q;
	logic tck_rise;
	logic tck_fall;

	stap_sync #(
		.W(STAP_DR_W + 3)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_async({i_pins.tck, i_pins.tms, i_pins.tdi, i_sys_in}),
		.o_sync(sync_out)
	);

	assign s_tck = sync_out[STAP_DR_W+2];
	assign s_tms = sync_out[STAP_DR_W+1];
	assign s_tdi = sync_out[STAP_DR_W];
	assign s_sys = sync_out[STAP_DR_W-1:0];

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tck_prev_q <= 1'b0;
		end else begin
			tck_prev_q <= s_tck;
		end
	end

	assign tck_rise = s_tck && !tck_prev_q;
	assign tck_fall = !s_tck && tck_prev_q;

	// ****************************************
	// tap controller
	// ****************************************
	stap_state_t state_q;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= ST_TLR;
		end else if (tck_rise) begin
			state_q <= tap_next(state_q, s_tms);
		end
	end

	// ****************************************
	// data-register strobes shared by bypass and data paths
	// ****************************************
	logic cap_dr_rise;
	logic shift_dr_rise;

	// tms and tdi come from the same sync stage as tck, so both are settled here
	assign cap_dr_rise = tck_rise && state_q == ST_CAP_DR;
	assign shift_dr_rise = tck_rise && state_q == ST_SHIFT_DR;

	// ****************************************
	// instruction register
	// ****************************************
	logic [STAP_IR_W-1:0] ir_sr_q;
	logic bypass_sel;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ir_sr_q <= STAP_IR_RESET;
		end else if (tck_rise) begin
			case (state_q)
				ST_CAP_IR: ir_sr_q <= STAP_IR_CAPTURE;
				ST_SHIFT_IR: ir_sr_q <= {s_tdi, ir_sr_q[STAP_IR_W-1:1]};
				default: ir_sr_q <= ir_sr_q;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ir <= STAP_IR_RESET;
		end else if (tck_fall) begin
			if (state_q == ST_TLR) begin
				o_ir <= STAP_IR_RESET;
			end else if (state_q == ST_UPD_IR) begin
				o_ir <= ir_sr_q;
			end
		end
	end

	assign bypass_sel = is_bypass(o_ir);

	// ****************************************
	// bypass and data registers
	// ****************************************
	logic byp_q;
	logic [STAP_DR_W-1:0] dr_sr_q;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			byp_q <= STAP_BYP_CAPTURE;
		end else if (bypass_sel) begin
			if (cap_dr_rise) begin
				byp_q <= STAP_BYP_CAPTURE;
			end else if (shift_dr_rise) begin
				byp_q <= s_tdi;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			dr_sr_q <= STAP_DR_RESET;
		end else if (!bypass_sel) begin
			if (cap_dr_rise) begin
				dr_sr_q <= s_sys;
			end else if (shift_dr_rise) begin
				dr_sr_q <= {s_tdi, dr_sr_q[STAP_DR_W-1:1]};
			end
		end
	end

	// ****************************************
	// tdo driver, falling edge only
	// ****************************************
	// serial data holds its last bit while the driver is off
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_tdo <= 1'b0;
		end else if (tck_fall) begin
			case (state_q)
				ST_SHIFT_IR: o_tdo <= ir_sr_q[0];
				ST_SHIFT_DR: o_tdo <= bypass_sel ? byp_q : dr_sr_q[0];
				default: o_tdo <= o_tdo;
			endcase
		end
	end

	// driver off on every fall outside the two shift states, pause included
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			case (state_q)
				ST_SHIFT_IR: o_tdo_oe_n <= 1'b0;
				ST_SHIFT_DR: o_tdo_oe_n <= 1'b0;
				default: o_tdo_oe_n <= 1'b1;
			endcase
		end
	end

	// ****************************************
	// parallel output stage and word hand-off
	// ****************************************
	logic push_q;
	logic buf_in_ready;
	logic upd_take;

	// a pending word blocks the stage: the update is dropped rather than overwrite it
	assign upd_take = tck_fall && state_q == ST_UPD_DR && !bypass_sel && !push_q;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_upd_data <= STAP_DR_RESET;
		end else if (upd_take) begin
			o_upd_data <= dr_sr_q;
		end
	end

	// a word still waiting for the buffer holds the stage; set wins over clear
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			push_q <= 1'b0;
		end else if (upd_take) begin
			push_q <= 1'b1;
		end else if (buf_in_ready) begin
			push_q <= 1'b0;
		end
	end

	stap_buf #(
		.W(STAP_DR_W)
	) u_buf (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_in_valid(push_q),
		.i_in_data(o_upd_data),
		.o_in_ready(buf_in_ready),
		.o_out_valid(o_word_valid),
		.o_out_data(o_word_data),
		.i_out_ready(i_word_ready)
	);

endmodule : stap_top

/* File: verif/stap_top_assertions.sv */
// checker of the scan port pin timing and word hand-off
// assumes it is bound to stap_top and sees only its ports
`timescale 1ns/10ps
module stap_top_chk import stap_pkg::*; (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// watched ports
	input wire stap_pkg::stap_pins_t i_pins,
	input wire logic o_tdo,
	input wire logic o_tdo_oe_n,
	input wire logic [stap_pkg::STAP_DR_W-1:0] o_upd_data,
	input wire logic [stap_pkg::STAP_IR_W-1:0] o_ir,
	input wire logic o_word_valid,
	input wire logic [stap_pkg::STAP_DR_W-1:0] o_word_data,
	input wire logic i_word_ready
);
	// ****************************************
	// properties
	// ****************************************
	default clocking dc @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	tdo_edge_a: assert property (!$stable(o_tdo) |-> !i_pins.tck)
		else $error("tdo moved while tck high");
	oe_edge_a: assert property (!$stable(o_tdo_oe_n) |-> !i_pins.tck)
		else $error("tdo enable moved while tck high");
	upd_edge_a: assert property (!$stable(o_upd_data) |-> !i_pins.tck)
		else $error("parallel stage moved while tck high");
	ir_edge_a: assert property (!$stable(o_ir) |-> !i_pins.tck)
		else $error("instruction moved while tck high");
	oe_off_hold_a: assert property ($rose(o_tdo_oe_n) |=> o_tdo_oe_n [*8])
		else $error("tdo driver came back too soon");
	oe_on_hold_a: assert property ($fell(o_tdo_oe_n) |=> !o_tdo_oe_n [*8])
		else $error("tdo driver dropped too soon");
	rise_quiet_a: assert property ($rose(i_pins.tck) |-> $stable(o_tdo) [*4])
		else $error("tdo moved after tck rise");
	word_hold_a: assert property (o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word_data))
		else $error("word lost while stalled");
	reset_state_a: assert property ($rose(i_resetn) |-> o_ir == STAP_IR_RESET && o_tdo_oe_n)
		else $error("wrong state after reset");
endmodule : stap_top_chk

bind stap_top stap_top_chk stap_top_chk_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_pins(i_pins),
	.o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .o_upd_data(o_upd_data), .o_ir(o_ir),
	.o_word_valid(o_word_valid), .o_word_data(o_word_data), .i_word_ready(i_word_ready));

/* File: verif/stap_ctrl.sv */
// model of the external scan controller
// assumes tck idles low between frames; tdi and tms idle high
`timescale 1ns/10ps
module stap_ctrl import stap_pkg::*; (
	// scan pins
	output stap_pkg::stap_pins_t o_pins,
	// serial return
	input wire logic i_tdo,
	input wire logic i_tdo_oe_n
);
	// ****************************************
	// one tck cycle
	// ****************************************
	initial o_pins = 3'h3;
	task cyc(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
		o_pins.tms = tms;
		o_pins.tdi = tdi;
		#62.5 o_pins.tck = 1'b1;
		// a released line reads as the inverse of its last value
		tdo = i_tdo_oe_n ? ~i_tdo : i_tdo;
		oe_n = i_tdo_oe_n;
		#62.5 o_pins.tck = 1'b0;
	endtask : cyc
endmodule : stap_ctrl

/* File: verif/stap_top_bench.sv */
// self-checking bench of the scan port
// assumes stap_ctrl drives the pins and the checker is bound
`timescale 1ns/10ps
module stap_top_bench;
	import stap_pkg::*;
	// ****************************************
	// harness
	// ****************************************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rdy = 1'b0;
	logic tdo, oe_n, wv, o, e;
	logic [7:0] sys_in = 8'h00;
	logic [7:0] upd, ir, wd, ins, u0;
	logic [7:0] lf = 8'h4B;
	logic [7:0] exp_q[$];
	stap_pkg::stap_pins_t pins;
	int failures = 0;
	int samples_checked = 0;
	stap_top stap_top_i (.i_core_clk(clk), .i_resetn(rst_n), .i_pins(pins), .o_tdo(tdo), .o_tdo_oe_n(oe_n),
		.i_sys_in(sys_in), .o_upd_data(upd), .o_ir(ir), .o_word_valid(wv), .o_word_data(wd),
		.i_word_ready(rdy));
	stap_ctrl stap_ctrl_i (.o_pins(pins), .i_tdo(tdo), .i_tdo_oe_n(oe_n));
	initial begin
		forever #4 clk = ~clk;
	end
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : nxt
	task chk(input logic [7:0] g, input logic [7:0] x);
		samples_checked++;
		if (g !== x) begin
			failures++;
			$display("Error at %0t: got %h want %h", $time, g, x);
		end
	endtask : chk
	task report_and_stop;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	// from run-test/idle through one scan and back; after bit pz the scan rests in pause
	task scan(input bit is_ir, input int n, input logic [7:0] din, input logic [7:0] x, input int pz);
		stap_ctrl_i.cyc(1'b1, 1'b1, o, e);
		if (is_ir)
			stap_ctrl_i.cyc(1'b1, 1'b1, o, e);
		stap_ctrl_i.cyc(1'b0, 1'b1, o, e);
		stap_ctrl_i.cyc(1'b0, 1'b1, o, e);
		for (int i = 0; i < n; i++) begin
			stap_ctrl_i.cyc(i == n - 1 || i == pz, din[i], o, e);
			chk({7'h00, o}, {7'h00, x[i]});
			chk({7'h00, e}, 8'h00);
			if (i == pz && i < n - 1) begin
				stap_ctrl_i.cyc(1'b0, 1'b1, o, e);
				chk({7'h00, e}, 8'h01);
				stap_ctrl_i.cyc(1'b0, 1'b1, o, e);
				stap_ctrl_i.cyc(1'b1, 1'b1, o, e);
				stap_ctrl_i.cyc(1'b0, 1'b1, o, e);
			end
		end
		stap_ctrl_i.cyc(1'b1, 1'b1, o, e);
		chk({7'h00, e}, 8'h01);
		stap_ctrl_i.cyc(1'b0, 1'b1, o, e);
	endtask : scan
	always @(posedge clk) begin
		if (rst_n && wv && rdy) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("Error at %0t: unexpected word", $time);
			end else
				chk(wd, exp_q.pop_front());
		end
	end
	initial begin
		#200000;
		failures++;
		report_and_stop;
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		chk(ir, STAP_IR_RESET);
		chk({7'h00, wv}, 8'h00);
		stap_ctrl_i.cyc(1'b0, 1'b1, o, e);
		scan(1'b1, 8, STAP_IR_BYPASS, STAP_IR_CAPTURE, -1);
		u0 = upd;
		scan(1'b0, 3, 8'h05, 8'h02, -1);
		chk(upd, u0);
		chk({7'h00, wv}, 8'h00);
		lf = nxt(lf);
		ins = lf & 8'hFE;
		scan(1'b1, 8, ins, STAP_IR_CAPTURE, 3);
		chk(ir, ins);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			#1 sys_in = nxt(lf);
			lf = nxt(sys_in);
			exp_q.push_back(lf);
			scan(1'b0, 8, lf, sys_in, k);
			chk(upd, lf);
		end
		for (int k = 0; k < 300 && exp_q.size() > 0; k++) begin
			@(posedge clk);
			#1 rdy = lf[0];
			lf = nxt(lf);
		end
		chk(8'(exp_q.size()), 8'h00);
		repeat (5) stap_ctrl_i.cyc(1'b1, 1'b1, o, e);
		repeat (8) @(posedge clk);
		chk(ir, STAP_IR_RESET);
		stap_ctrl_i.cyc(1'b0, 1'b1, o, e);
		lf = nxt(lf);
		scan(1'b0, 3, lf, {lf[6:0], 1'b0}, 0);
		report_and_stop;
	end
endmodule : stap_top_bench
